// *** common/fmdc_defs.svh ***
// Timing counts and field constants of the FSK modem digital core
`ifndef FMDC_DEFS_SVH
`define FMDC_DEFS_SVH

// ------------------------------------------------------------
// Clock and tone figures
// ------------------------------------------------------------
`define FMDC_CLK_HZ        10_000_000
`define FMDC_REF_HZ        1200
`define FMDC_MARK_HZ       1302
`define FMDC_SPACE_HZ      2097
`define FMDC_SEGMENTS      16
`define FMDC_PLL_OVERSMP   16
`define FMDC_LOCK_MAX_TICK 8
`define FMDC_DEMOD_SPLIT_HZ 1600

// ------------------------------------------------------------
// Derived cycle counts (integer division, all round down)
// ------------------------------------------------------------
`define FMDC_REF_HALF_CYC  (`FMDC_CLK_HZ / (2 * `FMDC_REF_HZ))
`define FMDC_MARK_STEP_CYC (`FMDC_CLK_HZ / (`FMDC_MARK_HZ * `FMDC_SEGMENTS))
`define FMDC_SPACE_STEP_CYC (`FMDC_CLK_HZ / (`FMDC_SPACE_HZ * `FMDC_SEGMENTS))
`define FMDC_PLL_TICK_CYC  (`FMDC_CLK_HZ / (`FMDC_REF_HZ * `FMDC_PLL_OVERSMP))
`define FMDC_DEMOD_THR_CYC (`FMDC_CLK_HZ / `FMDC_DEMOD_SPLIT_HZ)

// ------------------------------------------------------------
// Field values
// ------------------------------------------------------------
`define FMDC_TONE_MID      8'h80
`define FMDC_LFSR_SEED     7'h01
`define FMDC_SYS_DELAY_BITS 2
`define FMDC_BUF_DEPTH     2

`endif

// *** common/fmdc_pkg.sv ***
// Types shared by the FSK modem digital core
package fmdc_pkg;

    // ------------------------------------------------------------
    // Transmit state, Gray coded
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FMDC_TX_STANDBY = 2'b00,
        FMDC_TX_ACTIVE  = 2'b01
    } fmdc_tx_state_t;

    // ------------------------------------------------------------
    // Synthesizer position and level
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] segment;
        logic [7:0] level;
    } fmdc_tone_t;

    // ------------------------------------------------------------
    // Receive sampling state
    // ------------------------------------------------------------
    typedef struct packed {
        logic       demodBit;
        logic [3:0] phase;
        logic       syncClk;
    } fmdc_rx_t;

endpackage

// *** verilog/fmdc_core.sv ***
// FSK modem digital core: timing, tone synthesis, receive PLL and self-test
`include "fmdc_defs.svh"

module fmdc_core
    import fmdc_pkg::*;
#(
    parameter logic [12:0] REF_HALF_CYC  = 13'(`FMDC_REF_HALF_CYC),
    parameter logic [13:0] DEMOD_THR_CYC = 14'(`FMDC_DEMOD_THR_CYC)
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       txBit,
    input  wire logic       txBitValid,
    output logic            txBitReady,
    input  wire logic       txStandby,
    input  wire logic       selfTest,
    input  wire logic       inputFilterSelect,
    input  wire logic       filteredLineIn,
    input  wire logic       rawLineIn,
    input  wire logic       lockDisable,
    output logic [7:0]      lineToneOut,
    output logic            toneClkOut,
    output logic            syncClkOut,
    output logic            rxDataOut
);

    localparam logic [8:0] MARK_STEP  = 9'(`FMDC_MARK_STEP_CYC);
    localparam logic [8:0] SPACE_STEP = 9'(`FMDC_SPACE_STEP_CYC);
    localparam logic [9:0] PLL_TICK   = 10'(`FMDC_PLL_TICK_CYC);
    localparam logic [3:0] PHASE_CTR  = 4'(`FMDC_LOCK_MAX_TICK);
    localparam int         DLY        = `FMDC_SYS_DELAY_BITS;
    localparam int         DEPTH      = `FMDC_BUF_DEPTH;

    // ------------------------------------------------------------
    // Sine level for one of the 16 synthesizer segments
    // ------------------------------------------------------------
    function automatic logic [7:0] sineLevel(input logic [3:0] seg);
        logic [7:0] lvl;
        unique case (seg)
            4'h0: lvl = 8'h80;
            4'h1: lvl = 8'hB0;
            4'h2: lvl = 8'hDA;
            4'h3: lvl = 8'hF5;
            4'h4: lvl = 8'hFF;
            4'h5: lvl = 8'hF5;
            4'h6: lvl = 8'hDA;
            4'h7: lvl = 8'hB0;
            4'h8: lvl = 8'h80;
            4'h9: lvl = 8'h50;
            4'hA: lvl = 8'h26;
            4'hB: lvl = 8'h0B;
            4'hC: lvl = 8'h01;
            4'hD: lvl = 8'h0B;
            4'hE: lvl = 8'h26;
            4'hF: lvl = 8'h50;
        endcase
        return lvl;
    endfunction

    // ------------------------------------------------------------
    // Timing: 1200 Hz reference
    // ------------------------------------------------------------
    logic [12:0] refCnt_q, refCnt_d;
    logic        toneClk_q, toneClk_d;
    logic        bitStrobe;

    always_comb begin
        refCnt_d  = refCnt_q + 13'd1;
        toneClk_d = toneClk_q;
        bitStrobe = 1'b0;
        if (refCnt_q >= REF_HALF_CYC - 13'd1) begin
            refCnt_d  = '0;
            toneClk_d = ~toneClk_q;
            bitStrobe = ~toneClk_q;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            refCnt_q  <= '0;
            toneClk_q <= 1'b0;
        end else begin
            refCnt_q  <= refCnt_d;
            toneClk_q <= toneClk_d;
        end
    end

    // ------------------------------------------------------------
    // Transmit bit buffer
    // ------------------------------------------------------------
    // A host stalled by the bit clock keeps its bit, and a standby
    // transmitter stops draining, so the buffer fills honestly.
    logic [DEPTH-1:0] bufMem_q, bufMem_d;
    logic             wrIdx_q, wrIdx_d, rdIdx_q, rdIdx_d;
    logic [1:0]       bufCnt_q, bufCnt_d;
    logic             ready_q, ready_d;
    logic             curBit_q, curBit_d;
    logic             push, pop;
    fmdc_tx_state_t   txState_q, txState_d;

    always_comb begin
        bufMem_d  = bufMem_q;
        wrIdx_d   = wrIdx_q;
        rdIdx_d   = rdIdx_q;
        curBit_d  = curBit_q;
        txState_d = txStandby ? FMDC_TX_STANDBY : FMDC_TX_ACTIVE;
        push = txBitValid && ready_q;
        // host bits only in normal mode
        pop  = bitStrobe && (txState_q == FMDC_TX_ACTIVE) && !selfTest
               && (bufCnt_q != 2'd0);
        if (push) begin
            bufMem_d[wrIdx_q] = txBit;
            wrIdx_d = ~wrIdx_q;
        end
        if (pop) begin
            curBit_d = bufMem_q[rdIdx_q];
            rdIdx_d  = ~rdIdx_q;
        end
        bufCnt_d = bufCnt_q + {1'b0, push} - {1'b0, pop};
        ready_d  = bufCnt_d < 2'(DEPTH);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bufMem_q  <= '0;
            wrIdx_q   <= 1'b0;
            rdIdx_q   <= 1'b0;
            bufCnt_q  <= '0;
            ready_q   <= 1'b1;
            curBit_q  <= 1'b1;
            txState_q <= FMDC_TX_STANDBY;
        end else begin
            bufMem_q  <= bufMem_d;
            wrIdx_q   <= wrIdx_d;
            rdIdx_q   <= rdIdx_d;
            bufCnt_q  <= bufCnt_d;
            ready_q   <= ready_d;
            curBit_q  <= curBit_d;
            txState_q <= txState_d;
        end
    end

    // ------------------------------------------------------------
    // Self-test sequence and delay line
    // ------------------------------------------------------------
    logic [6:0]     lfsr_q, lfsr_d;
    logic [DLY-1:0] dly_q, dly_d;
    logic           srcBit;

    always_comb begin
        srcBit = selfTest ? lfsr_q[6] : curBit_q;
        lfsr_d = lfsr_q;
        dly_d  = dly_q;
        if (bitStrobe) begin
            // x^7 + x^6 + 1 per bit
            if (selfTest) begin
                lfsr_d = {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
            end
            dly_d = {dly_q[DLY-2:0], srcBit};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lfsr_q <= `FMDC_LFSR_SEED;
            dly_q  <= '0;
        end else begin
            lfsr_q <= lfsr_d;
            dly_q  <= dly_d;
        end
    end

    // ------------------------------------------------------------
    // Tone synthesizer
    // ------------------------------------------------------------
    logic [8:0] stepCnt_q, stepCnt_d;
    logic [8:0] stepLim;
    fmdc_tone_t tone_q, tone_d;

    always_comb begin
        stepLim   = srcBit ? MARK_STEP : SPACE_STEP;
        stepCnt_d = stepCnt_q + 9'd1;
        tone_d    = tone_q;
        if (txState_q == FMDC_TX_STANDBY && !selfTest) begin
            stepCnt_d      = '0;
            tone_d.segment = '0;
            tone_d.level   = `FMDC_TONE_MID;
        end else begin
            if (stepCnt_q >= stepLim - 9'd1) begin
                stepCnt_d      = '0;
                tone_d.segment = tone_q.segment + 4'd1;
            end
            tone_d.level = sineLevel(tone_d.segment);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stepCnt_q <= '0;
            tone_q    <= '{segment: 4'h0, level: `FMDC_TONE_MID};
        end else begin
            stepCnt_q <= stepCnt_d;
            tone_q    <= tone_d;
        end
    end

    // ------------------------------------------------------------
    // Receiver: input select and period demodulator
    // ------------------------------------------------------------
    // Inputs are sliced line levels; a mark has the longer period.
    logic        rxIn, rxPrev_q;
    logic [13:0] period_q, period_d;
    fmdc_rx_t    rx_q, rx_d;
    logic [9:0]  tick_q, tick_d;
    logic        rxData_q, rxData_d;
    logic        tickNow, sample;

    always_comb begin
        if (selfTest) begin
            rxIn = tone_q.level[7];
        end else begin
            rxIn = inputFilterSelect ? filteredLineIn : rawLineIn;
        end
        rx_d     = rx_q;
        period_d = (period_q == '1) ? period_q : period_q + 14'd1;
        if (rxIn && !rxPrev_q) begin
            rx_d.demodBit = period_q >= DEMOD_THR_CYC;
            period_d      = 14'd1;
        end

        tickNow = tick_q >= PLL_TICK - 10'd1;
        tick_d  = tickNow ? '0 : tick_q + 10'd1;
        if (tickNow) begin
            rx_d.phase = rx_q.phase + 4'd1;
        end
        if (!lockDisable && (rx_d.demodBit != rx_q.demodBit)) begin
            rx_d.phase = '0;
            tick_d     = '0;
        end
        rx_d.syncClk = lockDisable ? toneClk_d : (rx_d.phase >= PHASE_CTR);
        sample       = rx_d.syncClk && !rx_q.syncClk;

        rxData_d = rxData_q;
        if (sample) begin
            rxData_d = selfTest ? (rx_q.demodBit != dly_q[DLY-1]) : rx_q.demodBit;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxPrev_q <= 1'b0;
            period_q <= '0;
            rx_q     <= '{demodBit: 1'b1, phase: 4'h0, syncClk: 1'b0};
            tick_q   <= '0;
            rxData_q <= 1'b1;
        end else begin
            rxPrev_q <= rxIn;
            period_q <= period_d;
            rx_q     <= rx_d;
            tick_q   <= tick_d;
            rxData_q <= rxData_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    assign txBitReady  = ready_q;
    assign lineToneOut = tone_q.level;
    assign toneClkOut  = toneClk_q;
    assign syncClkOut  = rx_q.syncClk;
    assign rxDataOut   = rxData_q;

endmodule

// *** verif/fmdc_line_model.sv ***
// Line side model: sliced mark or space tones on both receive inputs
`include "fmdc_defs.svh"
module fmdc_line_model (
    input  wire logic core_clk,
    input  wire logic filtMark,
    input  wire logic rawMark,
    output logic      filteredLineIn,
    output logic      rawLineIn
);
    timeunit 1ns;
    timeprecision 1ns;
    int fc = 0;
    int rc = 0;
    function automatic int hp(input logic m);
        return m ? `FMDC_MARK_STEP_CYC * 8 : `FMDC_SPACE_STEP_CYC * 8;
    endfunction
    initial begin
        filteredLineIn = 1'h0;
        rawLineIn = 1'h0;
    end
    always @(posedge core_clk) begin
        fc <= (fc >= hp(filtMark)) ? 1 : fc + 1;
        rc <= (rc >= hp(rawMark)) ? 1 : rc + 1;
        if (fc >= hp(filtMark)) filteredLineIn <= !filteredLineIn;
        if (rc >= hp(rawMark)) rawLineIn <= !rawLineIn;
    end
endmodule

// *** verif/fmdc_core_chk.sv ***
// Port checker of the FSK modem digital core
`include "fmdc_defs.svh"
module fmdc_core_chk
    import fmdc_pkg::*;
#(
    parameter logic [12:0] REF_HALF_CYC  = 13'(`FMDC_REF_HALF_CYC),
    parameter logic [13:0] DEMOD_THR_CYC = 14'(`FMDC_DEMOD_THR_CYC)
) (
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       txBit,
    input wire logic       txBitValid,
    input wire logic       txBitReady,
    input wire logic       txStandby,
    input wire logic       selfTest,
    input wire logic       inputFilterSelect,
    input wire logic       filteredLineIn,
    input wire logic       rawLineIn,
    input wire logic       lockDisable,
    input wire logic [7:0] lineToneOut,
    input wire logic       toneClkOut,
    input wire logic       syncClkOut,
    input wire logic       rxDataOut
);
    logic [12:0] hCnt_q;
    logic [10:0] lCnt_q;
    logic [7:0]  lvl_q;
    logic        clk_q;
    logic        hSeen_q;
    logic        lSeen_q;
    wire         hChg = toneClkOut != clk_q;
    wire         lChg = lineToneOut != lvl_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hCnt_q <= '0;
            lCnt_q <= '0;
            lvl_q <= 8'h80;
            clk_q <= 1'h0;
            hSeen_q <= 1'h0;
            lSeen_q <= 1'h0;
        end else begin
            clk_q <= toneClkOut;
            lvl_q <= lineToneOut;
            hCnt_q <= hChg ? 13'h0001 : hCnt_q + 13'h0001;
            hSeen_q <= hSeen_q | hChg;
            lCnt_q <= (lChg | txStandby) ? 11'h001 : lCnt_q + 11'h001;
            lSeen_q <= (lSeen_q | lChg) & !txStandby;
        end
    end
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    AST_CLK_HALF:
        assert property (hSeen_q |-> (hChg ? hCnt_q == REF_HALF_CYC : hCnt_q < REF_HALF_CYC))
        else $error("tone clock half period wrong");
    AST_TONE_RUN:
        assert property (lSeen_q && !txStandby |-> lCnt_q <= 11'h3c2)
        else $error("tone level held too long");
    AST_STBY_MID:
        assert property ((txStandby && !selfTest) [*2] |=> lineToneOut == 8'h80)
        else $error("standby level not mid");
    AST_STBY_HOLD:
        assert property ((txStandby && !txBitReady) [*2] |=> !txBitReady)
        else $error("buffer drained in standby");
    AST_BUF_FULL:
        assert property ((txStandby && txBitValid && txBitReady) [*2] |=> !txBitReady)
        else $error("ready high with two bits held");
    AST_READY_FALL:
        assert property ($fell(txBitReady) |-> $past(txBitValid))
        else $error("ready fell without a take");
    AST_SYNC_REF:
        assert property (lockDisable && $past(lockDisable, 8) && $rose(toneClkOut)
                         |-> ##[0:3] syncClkOut)
        else $error("sync clock not following reference");
    AST_RX_SYNC:
        assert property ($changed(rxDataOut) |-> $rose(syncClkOut))
        else $error("receive data changed off sync edge");
endmodule

bind fmdc_core fmdc_core_chk #(.REF_HALF_CYC(REF_HALF_CYC), .DEMOD_THR_CYC(DEMOD_THR_CYC)) i_chk (
    .core_clk(core_clk), .reset_n(reset_n), .txBit(txBit), .txBitValid(txBitValid),
    .txBitReady(txBitReady), .txStandby(txStandby), .selfTest(selfTest),
    .inputFilterSelect(inputFilterSelect), .filteredLineIn(filteredLineIn),
    .rawLineIn(rawLineIn), .lockDisable(lockDisable), .lineToneOut(lineToneOut),
    .toneClkOut(toneClkOut), .syncClkOut(syncClkOut), .rxDataOut(rxDataOut)
);

// *** verif/test_fmdc_core.sv ***
// Self-checking bench of the FSK modem digital core
`include "fmdc_defs.svh"
module test_fmdc_core
    import fmdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk = 0, reset_n = 0, txBit = 0, txBitValid = 0, txStandby = 1;
    logic       selfTest = 0, inputFilterSelect = 1, lockDisable = 0, filtMark = 1;
    logic       rawMark = 0;
    logic       txBitReady, toneClkOut, syncClkOut, rxDataOut, filteredLineIn, rawLineIn;
    logic [7:0] lineToneOut;
    int         errTotal = 0;
    int         testsRun = 0;
    fmdc_core i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .txBit(txBit), .txBitValid(txBitValid),
        .txBitReady(txBitReady), .txStandby(txStandby), .selfTest(selfTest),
        .inputFilterSelect(inputFilterSelect), .filteredLineIn(filteredLineIn),
        .rawLineIn(rawLineIn), .lockDisable(lockDisable), .lineToneOut(lineToneOut),
        .toneClkOut(toneClkOut), .syncClkOut(syncClkOut), .rxDataOut(rxDataOut)
    );
    fmdc_line_model i_line (
        .core_clk(core_clk), .filtMark(filtMark), .rawMark(rawMark),
        .filteredLineIn(filteredLineIn), .rawLineIn(rawLineIn)
    );
    initial begin
        forever #50 core_clk = !core_clk;
    end
    // Full 32 bits: the tone and sync periods do not fit in 13
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            errTotal++;
            $display("[FAIL] %s expected %0h seen %0h", w, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Counts settled samples until s goes low, then high again
    task automatic rise(ref logic s, input int lim, output int n);
        n = 0;
        while (s !== 1'h0 && n < lim) begin
            cyc(1);
            n++;
        end
        while (s !== 1'h1 && n < lim) begin
            cyc(1);
            n++;
        end
        chk("edge wait", 1'h1, n < lim);
    endtask
    // Ready is judged settled before the edge that takes the bit
    task automatic push(input logic b);
        @(posedge core_clk);
        txBit <= b;
        txBitValid <= 1'h1;
        @(negedge core_clk);
        while (txBitReady !== 1'h1) @(negedge core_clk);
        @(posedge core_clk);
        txBitValid <= 1'h0;
    endtask
    // First run only aligns; a doubled run is a repeated table level
    task automatic runs(input int step, input string w);
        int n;
        logic [7:0] v;
        for (int k = 0; k < 3; k++) begin
            v = lineToneOut;
            n = 0;
            while (lineToneOut === v && n < 2000) begin
                cyc(1);
                n++;
            end
            if (k > 0) chk(w, 1'h1, n == step || n == 2 * step);
        end
    endtask
    task automatic t_reset();
        cyc(3);
        chk("txBitReady", 1'h1, txBitReady);
        chk("lineToneOut", 8'h80, lineToneOut);
        chk("clocks", 2'h0, {toneClkOut, syncClkOut});
        chk("rxDataOut", 1'h1, rxDataOut);
        @(posedge core_clk);
        reset_n <= 1'h1;
        $display("test reset done");
    endtask
    task automatic t_clk();
        int n;
        rise(toneClkOut, 9000, n);
        rise(toneClkOut, 9000, n);
        chk("tone clock period", 2 * `FMDC_REF_HALF_CYC, n);
        $display("test timing done");
    endtask
    task automatic t_buf();
        int n;
        push(1'h1);
        push(1'h0);
        cyc(2);
        chk("txBitReady full", 1'h0, txBitReady);
        @(posedge core_clk);
        txStandby <= 1'h0;
        rise(txBitReady, 9000, n);
        runs(`FMDC_MARK_STEP_CYC, "mark run");
        rise(toneClkOut, 9000, n);
        cyc(2);
        runs(`FMDC_SPACE_STEP_CYC, "space run");
        $display("test buffer and tone done");
    endtask
    task automatic t_stby();
        @(posedge core_clk);
        txStandby <= 1'h1;
        cyc(3);
        chk("standby level", 8'h80, lineToneOut);
        $display("test standby done");
    endtask
    task automatic t_rx();
        int n;
        rise(syncClkOut, 9000, n);
        chk("rx filtered mark", 1'h1, rxDataOut);
        @(posedge core_clk);
        inputFilterSelect <= 1'h0;
        cyc(9600);
        rise(syncClkOut, 9000, n);
        chk("rx raw space", 1'h0, rxDataOut);
        rise(syncClkOut, 9000, n);
        chk("sync period", 16 * `FMDC_PLL_TICK_CYC, n);
        $display("test receive done");
    endtask
    task automatic t_lock();
        int n;
        @(posedge core_clk);
        lockDisable <= 1'h1;
        rise(toneClkOut, 9000, n);
        cyc(4);
        chk("sync follows ref", 1'h1, syncClkOut);
        @(posedge core_clk);
        lockDisable <= 1'h0;
        $display("test lock disable done");
    endtask
    task automatic t_self();
        int n;
        @(posedge core_clk);
        txStandby <= 1'h0;
        selfTest <= 1'h1;
        cyc(`FMDC_REF_HALF_CYC);
        for (int k = 0; k < 2; k++) begin
            rise(syncClkOut, 9000, n);
            chk("self-test result", 1'h0, rxDataOut);
        end
        @(posedge core_clk);
        selfTest <= 1'h0;
        $display("test self-test done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        t_reset();
        t_clk();
        t_buf();
        t_stby();
        t_rx();
        t_lock();
        t_self();
        report_and_stop();
    end
    // Whole sequence needs about 90k cycles at worst
    initial begin
        #(100_000 * 100);
        errTotal++;
        report_and_stop();
    end
endmodule
